// file: core/gfd_pkg.sv
// constants, register map and types of the get-features command decoder
package gfd_pkg;

    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CMD_DW10 = 8'h00;
    localparam logic [7:0] OFS_PRP2_LO = 8'h04;
    localparam logic [7:0] OFS_PRP2_HI = 8'h08;
    localparam logic [7:0] OFS_BUF_OFS = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_CFG_FID = 8'h14;
    localparam logic [7:0] OFS_CFG_VALUE = 8'h18;
    localparam logic [7:0] OFS_CFG_CAP = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_RESULT = 8'h24;
    localparam logic [7:0] OFS_XFER2_LO = 8'h28;
    localparam logic [7:0] OFS_XFER2_HI = 8'h2C;
    localparam logic [7:0] OFS_OPT_SUPPORT = 8'h30;

    // command dword ten fields
    localparam int FID_LSB = 0;
    localparam int FID_W = 8;
    localparam int SEL_LSB = 8;
    localparam int SEL_W = 3;

    // select codes
    localparam logic [2:0] SEL_CURRENT = 3'h0;
    localparam logic [2:0] SEL_DEFAULT = 3'h1;
    localparam logic [2:0] SEL_SAVED = 3'h2;
    localparam logic [2:0] SEL_CAPS = 3'h3;

    // capability bits of a feature entry
    localparam int CAP_W = 4;
    localparam int CAP_SAVE_BIT = 0;
    localparam int CAP_NS_BIT = 1;
    localparam int CAP_CHG_BIT = 2;
    localparam int CAP_STRUCT_BIT = 3;

    // optional command support bit for the select field
    localparam int OPT_SEL_BIT = 4;

    // control register bits
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SET_BIT = 1;
    localparam int CTRL_SAVE_BIT = 2;
    localparam int CTRL_CFG_BIT = 3;

    // status register bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ERR_SEL_BIT = 2;
    localparam int ST_ERR_FID_BIT = 3;
    localparam int ST_SPLIT_BIT = 4;
    localparam int ST_DATA_BIT = 5;
    localparam int ST_EFF_SEL_LSB = 8;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [11:0] RST_BUF_OFS = 12'h000;
    localparam logic [3:0] RST_CAP = 4'h0;

    // buffer geometry and feature count defaults
    localparam int PAGE_BYTES_DEF = 4096;
    localparam int STRUCT_BYTES_DEF = 64;
    localparam int FEAT_NUM_DEF = 16;

    typedef enum logic [2:0] {
        GFD_IDLE = 3'b001,
        GFD_LOOK = 3'b010,
        GFD_DONE = 3'b100
    } gfd_state_t;

endpackage

// file: core/gfd_field_decode.sv
// splits command dword ten into feature identifier and select code
`timescale 1ns/10ps
`default_nettype none
module gfd_field_decode
(
    // command word
    input wire logic [31:0] dw10_i,
    input wire logic sel_supported_i,
    // decoded fields
    output logic [7:0] fid_o,
    output logic [2:0] sel_o,
    output logic sel_rsvd_o
);
    wire [2:0] sel_raw = dw10_i[gfd_pkg::SEL_LSB +: gfd_pkg::SEL_W];

    assign fid_o = dw10_i[gfd_pkg::FID_LSB +: gfd_pkg::FID_W];
    // without select support the field is not looked at
    assign sel_o = sel_supported_i ? sel_raw : gfd_pkg::SEL_CURRENT;
    assign sel_rsvd_o = sel_supported_i & sel_raw[2];
endmodule
`default_nettype wire

// file: core/gfd_attr_store.sv
// per-feature current, default and saved values with capability bits
`timescale 1ns/10ps
`default_nettype none
module gfd_attr_store
#(
    parameter int FEAT_NUM = gfd_pkg::FEAT_NUM_DEF,
    parameter int IDX_W = $clog2(FEAT_NUM)
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // update port
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [31:0] wr_value_i,
    input wire logic [gfd_pkg::CAP_W-1:0] wr_cap_i,
    input wire logic cfg_i,
    input wire logic set_i,
    input wire logic save_i,
    // lookup port, one cycle latency
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [31:0] cur_o,
    output logic [31:0] def_o,
    output logic [31:0] sav_o,
    output logic sav_valid_o,
    output logic [gfd_pkg::CAP_W-1:0] cap_o
);
    logic [31:0] cur_mem [FEAT_NUM];
    logic [31:0] def_mem [FEAT_NUM];
    logic [31:0] sav_mem [FEAT_NUM];
    logic [FEAT_NUM-1:0] sav_valid;
    logic [gfd_pkg::CAP_W-1:0] cap_mem [FEAT_NUM];

    wire do_save = set_i & save_i & cap_mem[wr_idx_i][gfd_pkg::CAP_SAVE_BIT];

    always_ff @(posedge clk_i)
    begin
        if (cfg_i | set_i)
            cur_mem[wr_idx_i] <= wr_value_i;
        if (cfg_i)
            def_mem[wr_idx_i] <= wr_value_i;
        if (do_save)
            sav_mem[wr_idx_i] <= wr_value_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sav_valid <= '0;
            for (int i = 0; i < FEAT_NUM; i++)
                cap_mem[i] <= gfd_pkg::RST_CAP;
        end
        else
        begin
            if (cfg_i)
                cap_mem[wr_idx_i] <= wr_cap_i;
            // a save in the same cycle as a configure wins
            if (do_save)
                sav_valid[wr_idx_i] <= 1'b1;
            else if (cfg_i)
                sav_valid[wr_idx_i] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        cur_o <= cur_mem[rd_idx_i];
        def_o <= def_mem[rd_idx_i];
        sav_o <= sav_mem[rd_idx_i];
        sav_valid_o <= rst_i ? 1'b0 : sav_valid[rd_idx_i];
        cap_o <= rst_i ? gfd_pkg::RST_CAP : cap_mem[rd_idx_i];
    end
endmodule
`default_nettype wire

// file: core/gfd_top.sv
// get-features command decoder with wishbone register access
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module gfd_top
#(
    parameter int FEAT_NUM = gfd_pkg::FEAT_NUM_DEF,
    parameter int PAGE_BYTES = gfd_pkg::PAGE_BYTES_DEF,
    parameter int STRUCT_BYTES = gfd_pkg::STRUCT_BYTES_DEF,
    parameter bit SEL_SUPPORTED = 1'b1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [gfd_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // completion and transfer result
    output logic cpl_valid_o,
    output logic cpl_err_o,
    output logic [31:0] cpl_dw0_o,
    output logic xfer_data_o,
    output logic xfer_split_o,
    output logic [63:0] xfer_addr2_o
);
    localparam int IDX_W = $clog2(FEAT_NUM);

    if (FEAT_NUM < 2 || FEAT_NUM > 256)
        $error("FEAT_NUM must lie between 2 and 256");
    if (STRUCT_BYTES < 1 || STRUCT_BYTES > PAGE_BYTES)
        $error("STRUCT_BYTES must lie between 1 and PAGE_BYTES");
    // the buffer offset register holds twelve bits, so a page may not be larger
    if (PAGE_BYTES < 1 || PAGE_BYTES > 4096)
        $error("PAGE_BYTES must lie between 1 and 4096");

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    gfd_pkg::gfd_state_t state;
    gfd_pkg::gfd_state_t next_state;

    logic [31:0] cmd_dw10;
    logic [31:0] prp2_lo;
    logic [31:0] prp2_hi;
    logic [11:0] buf_ofs;
    logic [7:0] cfg_fid;
    logic [31:0] cfg_value;
    logic [gfd_pkg::CAP_W-1:0] cfg_cap;
    logic done;
    logic err_sel;
    logic err_fid;
    logic [2:0] eff_sel;

    // bus request decode
    wire req = wb_cyc_i & wb_stb_i;
    // a write lands at the edge that samples ack high, once per request
    wire wr_en = req & wb_we_i & wb_ack_o;
    wire idle = state == gfd_pkg::GFD_IDLE;
    wire hit_dw10 = wb_adr_i == gfd_pkg::OFS_CMD_DW10;
    wire hit_prp2_lo = wb_adr_i == gfd_pkg::OFS_PRP2_LO;
    wire hit_prp2_hi = wb_adr_i == gfd_pkg::OFS_PRP2_HI;
    wire hit_buf_ofs = wb_adr_i == gfd_pkg::OFS_BUF_OFS;
    wire hit_ctrl = wb_adr_i == gfd_pkg::OFS_CTRL;
    wire hit_cfg_fid = wb_adr_i == gfd_pkg::OFS_CFG_FID;
    wire hit_cfg_value = wb_adr_i == gfd_pkg::OFS_CFG_VALUE;
    wire hit_cfg_cap = wb_adr_i == gfd_pkg::OFS_CFG_CAP;
    wire hit_status = wb_adr_i == gfd_pkg::OFS_STATUS;
    wire hit_result = wb_adr_i == gfd_pkg::OFS_RESULT;
    wire hit_xfer_lo = wb_adr_i == gfd_pkg::OFS_XFER2_LO;
    wire hit_xfer_hi = wb_adr_i == gfd_pkg::OFS_XFER2_HI;
    wire hit_opt = wb_adr_i == gfd_pkg::OFS_OPT_SUPPORT;

    // command words are frozen while a lookup runs
    wire cmd_wr = wr_en & idle;
    wire ctrl_wr = wr_en & hit_ctrl & wb_sel_i[0];
    wire start = ctrl_wr & idle & wb_dat_i[gfd_pkg::CTRL_START_BIT];
    // commits reach the store only for identifiers that exist
    wire cfg_fid_ok = {1'b0, cfg_fid} < 9'(FEAT_NUM);
    wire set_cmd = ctrl_wr & cfg_fid_ok & wb_dat_i[gfd_pkg::CTRL_SET_BIT];
    wire cfg_cmd = ctrl_wr & cfg_fid_ok & wb_dat_i[gfd_pkg::CTRL_CFG_BIT];
    wire save_cmd = wb_dat_i[gfd_pkg::CTRL_SAVE_BIT];

    // field decode of the pending command
    wire [7:0] fid;
    wire [2:0] sel;
    wire sel_rsvd;

    gfd_field_decode u_decode
    (
        .dw10_i(cmd_dw10),
        .sel_supported_i(SEL_SUPPORTED),
        .fid_o(fid),
        .sel_o(sel),
        .sel_rsvd_o(sel_rsvd)
    );

    // feature attribute store
    wire [31:0] st_cur;
    wire [31:0] st_def;
    wire [31:0] st_sav;
    wire st_sav_valid;
    wire [gfd_pkg::CAP_W-1:0] st_cap;

    gfd_attr_store #(
        .FEAT_NUM(FEAT_NUM),
        .IDX_W(IDX_W)
    ) u_store
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_idx_i(cfg_fid[IDX_W-1:0]),
        .wr_value_i(cfg_value),
        .wr_cap_i(cfg_cap),
        .cfg_i(cfg_cmd),
        .set_i(set_cmd),
        .save_i(save_cmd),
        .rd_idx_i(fid[IDX_W-1:0]),
        .cur_o(st_cur),
        .def_o(st_def),
        .sav_o(st_sav),
        .sav_valid_o(st_sav_valid),
        .cap_o(st_cap)
    );

    // result of the lookup, valid in the lookup state
    // the store answers one cycle after the index, which is steady once a command is taken
    wire fid_ok = {1'b0, fid} < 9'(FEAT_NUM);
    wire cmd_err = sel_rsvd | ~fid_ok;
    wire no_saved = ~st_cap[gfd_pkg::CAP_SAVE_BIT] | ~st_sav_valid;
    wire [2:0] sel_used = (sel == gfd_pkg::SEL_SAVED && no_saved) ? gfd_pkg::SEL_DEFAULT : sel;
    wire [31:0] caps_word = {29'h0, st_cap[gfd_pkg::CAP_CHG_BIT], st_cap[gfd_pkg::CAP_NS_BIT],
        st_cap[gfd_pkg::CAP_SAVE_BIT]};
    wire [31:0] value_word = (sel_used == gfd_pkg::SEL_CAPS) ? caps_word :
        (sel_used == gfd_pkg::SEL_SAVED) ? st_sav :
        (sel_used == gfd_pkg::SEL_DEFAULT) ? st_def : st_cur;
    wire [31:0] next_dw0 = cmd_err ? gfd_pkg::RST_WORD : value_word;
    // capabilities come back in dword zero only, never through the buffer
    wire next_data = ~cmd_err & st_cap[gfd_pkg::CAP_STRUCT_BIT] & (sel_used != gfd_pkg::SEL_CAPS);
    // a buffer that ends right on the page edge needs no second pointer
    wire [31:0] buf_end = {20'h0, buf_ofs} + 32'(STRUCT_BYTES);
    wire next_split = next_data & (buf_end > 32'(PAGE_BYTES));
    // the second pointer is a plain buffer address, never walked as a list
    wire [63:0] next_addr2 = next_split ? {prp2_hi, prp2_lo} : 64'h0;

    // command sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            gfd_pkg::GFD_IDLE:
                if (start)
                    next_state = gfd_pkg::GFD_LOOK;
            gfd_pkg::GFD_LOOK:
                next_state = gfd_pkg::GFD_DONE;
            gfd_pkg::GFD_DONE:
                next_state = gfd_pkg::GFD_IDLE;
            default:
                next_state = gfd_pkg::GFD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= gfd_pkg::GFD_IDLE;
        else
            state <= next_state;
    end

    // latched completion
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cpl_valid_o <= 1'b0;
            cpl_err_o <= 1'b0;
            cpl_dw0_o <= gfd_pkg::RST_WORD;
            xfer_data_o <= 1'b0;
            xfer_split_o <= 1'b0;
            xfer_addr2_o <= 64'h0;
            err_sel <= 1'b0;
            err_fid <= 1'b0;
            eff_sel <= gfd_pkg::SEL_CURRENT;
        end
        else
        begin
            cpl_valid_o <= state == gfd_pkg::GFD_LOOK;
            if (state == gfd_pkg::GFD_LOOK)
            begin
                cpl_err_o <= cmd_err;
                cpl_dw0_o <= next_dw0;
                xfer_data_o <= next_data;
                xfer_split_o <= next_split;
                xfer_addr2_o <= next_addr2;
                err_sel <= sel_rsvd;
                err_fid <= ~fid_ok;
                eff_sel <= sel_used;
            end
        end
    end

    // done is set at the end of a lookup and cleared by the next start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            done <= 1'b0;
        else if (state == gfd_pkg::GFD_LOOK)
            done <= 1'b1;
        else if (start)
            done <= 1'b0;
    end

    // only the in-page offset bits of the merged word are kept
    wire [31:0] buf_ofs_merged = merge({20'h0, buf_ofs}, wb_dat_i, wb_sel_i);

    // software written registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_dw10 <= gfd_pkg::RST_WORD;
            prp2_lo <= gfd_pkg::RST_WORD;
            prp2_hi <= gfd_pkg::RST_WORD;
            buf_ofs <= gfd_pkg::RST_BUF_OFS;
        end
        else
        begin
            if (cmd_wr & hit_dw10)
                cmd_dw10 <= merge(cmd_dw10, wb_dat_i, wb_sel_i);
            if (cmd_wr & hit_prp2_lo)
                prp2_lo <= merge(prp2_lo, wb_dat_i, wb_sel_i);
            if (cmd_wr & hit_prp2_hi)
                prp2_hi <= merge(prp2_hi, wb_dat_i, wb_sel_i);
            if (cmd_wr & hit_buf_ofs)
                buf_ofs <= buf_ofs_merged[11:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_fid <= 8'h00;
            cfg_value <= gfd_pkg::RST_WORD;
            cfg_cap <= gfd_pkg::RST_CAP;
        end
        else
        begin
            if (wr_en & hit_cfg_fid & wb_sel_i[0])
                cfg_fid <= wb_dat_i[7:0];
            if (wr_en & hit_cfg_value)
                cfg_value <= merge(cfg_value, wb_dat_i, wb_sel_i);
            if (wr_en & hit_cfg_cap & wb_sel_i[0])
                cfg_cap <= wb_dat_i[gfd_pkg::CAP_W-1:0];
        end
    end

    // read data
    // busy, done, both error flags, split, data, then the select actually served
    wire [31:0] status_word = {21'h0, eff_sel, 2'b00, xfer_data_o, xfer_split_o, err_fid, err_sel, done, ~idle};
    wire [31:0] opt_word = 32'(SEL_SUPPORTED) << gfd_pkg::OPT_SEL_BIT;
    wire [31:0] rd_data = hit_dw10 ? cmd_dw10 :
        hit_prp2_lo ? prp2_lo :
        hit_prp2_hi ? prp2_hi :
        hit_buf_ofs ? {20'h0, buf_ofs} :
        hit_cfg_fid ? {24'h0, cfg_fid} :
        hit_cfg_value ? cfg_value :
        hit_cfg_cap ? {28'h0, cfg_cap} :
        hit_status ? status_word :
        hit_result ? cpl_dw0_o :
        hit_xfer_lo ? xfer_addr2_o[31:0] :
        hit_xfer_hi ? xfer_addr2_o[63:32] :
        hit_opt ? opt_word : 32'h0000_0000;

    // one answer per request, ack drops in the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= gfd_pkg::RST_WORD;
        end
        else
        begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= (req & ~wb_we_i & ~wb_ack_o) ? rd_data : gfd_pkg::RST_WORD;
        end
    end
endmodule
`default_nettype wire

// file: testbench/gfd_checker.sv
// port-level assertions for the get-features decoder
`timescale 1ns/10ps
`default_nettype none
module gfd_checker
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave side
    input wire logic [gfd_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // completion and transfer result
    input wire logic cpl_valid_o,
    input wire logic cpl_err_o,
    input wire logic [31:0] cpl_dw0_o,
    input wire logic xfer_data_o,
    input wire logic xfer_split_o,
    input wire logic [63:0] xfer_addr2_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // start written to the control register, taken at this edge
    wire start = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == gfd_pkg::OFS_CTRL;

    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RD_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_START_CPL: assert property (start |-> !cpl_valid_o ##2 cpl_valid_o)
        else $error("completion not two cycles after start");
    AST_CPL_PULSE: assert property (cpl_valid_o |=> !cpl_valid_o [*2])
        else $error("completion pulse too long");
    AST_ERR_CLEAN: assert property (cpl_valid_o && cpl_err_o |-> !xfer_data_o && cpl_dw0_o == 32'h0)
        else $error("error completion carries data");
    AST_NODATA: assert property (cpl_valid_o && !xfer_data_o |-> !xfer_split_o)
        else $error("second pointer used without data structure");
    AST_SPLIT_ADDR: assert property (cpl_valid_o && !xfer_split_o |-> xfer_addr2_o == 64'h0)
        else $error("second address without page crossing");
    AST_HOLD: assert property (!cpl_valid_o |-> $stable(cpl_dw0_o) && $stable(xfer_addr2_o))
        else $error("completion result changed between commands");

    cover property (start);
    cover property (cpl_valid_o && cpl_err_o);
    cover property (cpl_valid_o && xfer_split_o);
endmodule
bind gfd_top gfd_checker chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .cpl_valid_o, .cpl_err_o, .cpl_dw0_o, .xfer_data_o, .xfer_split_o,
    .xfer_addr2_o);
`default_nettype wire

// file: testbench/gfd_host_model.sv
// host software model: wishbone master issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module gfd_host_model
(
    // clock
    input wire logic clk_i,
    // wishbone master
    output logic [gfd_pkg::ADDR_W-1:0] wb_adr_o,
    output logic [31:0] wb_dat_o,
    output logic [3:0] wb_sel_o,
    output logic wb_we_o,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    initial
    begin
        wb_adr_o = '0;
        wb_dat_o = '0;
        wb_sel_o = 4'h0;
        wb_we_o = 1'b0;
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
    end

    // called right after a rising edge; leaves one idle cycle behind
    task automatic xfer(input logic we, input logic [gfd_pkg::ADDR_W-1:0] adr, input logic [31:0] d,
        output logic [31:0] q);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_dat_o <= d;
        wb_sel_o <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        // released lines do not keep the last value
        wb_adr_o <= ~adr;
        wb_dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: testbench/test_get_features_cmd_decode.sv
// self-checking bench for the get-features decoder
`timescale 1ns/10ps
`default_nettype none
module test_get_features_cmd_decode;
    localparam logic [63:0] PRP2 = 64'h0000_0012_3456_7000;
    logic clk_i, rst_i, we, cyc, stb, ack, cv, ce, xd, xs;
    logic [gfd_pkg::ADDR_W-1:0] adr;
    logic [31:0] wdat, rdat, dw0;
    logic [3:0] sel;
    logic [63:0] a2;
    int num_errors = 0;
    int cmp_count = 0;

    gfd_host_model host_u (.clk_i(clk_i), .wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel), .wb_we_o(we),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_dat_i(rdat), .wb_ack_i(ack));
    gfd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .cpl_valid_o(cv),
        .cpl_err_o(ce), .cpl_dw0_o(dw0), .xfer_data_o(xd), .xfer_split_o(xs), .xfer_addr2_o(a2));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host_u.xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(name, {32'h0, exp}, {32'h0, q});
    endtask

    // commit through the control register: 8 configure, 2 set, 6 set and save
    task automatic cfg(input logic [7:0] fid, input logic [31:0] v, input logic [31:0] ctrl);
        wr(gfd_pkg::OFS_CFG_FID, {24'h0, fid});
        wr(gfd_pkg::OFS_CFG_VALUE, v);
        wr(gfd_pkg::OFS_CTRL, ctrl);
    endtask

    // issue one command and compare the whole completion
    task automatic run(input logic [31:0] dw10, input logic [11:0] ofs, input logic err,
        input logic [31:0] d0, input logic data, input logic split);
        int n;
        wr(gfd_pkg::OFS_CMD_DW10, dw10);
        wr(gfd_pkg::OFS_BUF_OFS, {20'h0, ofs});
        wr(gfd_pkg::OFS_CTRL, 32'h0000_0001);
        n = 0;
        while (cv !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("cpl_valid", 64'h1, {63'h0, cv});
        chk("completion", {29'h0, err, data, split, d0}, {29'h0, ce, xd, xs, dw0});
        chk("addr2", split ? PRP2 : 64'h0, a2);
        rdc("result", gfd_pkg::OFS_RESULT, d0);
    endtask

    initial
    begin
        #400000;
        num_errors++;
        $display("Error watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial
    begin
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("status", gfd_pkg::OFS_STATUS, 32'h0);
        rdc("opt_support", gfd_pkg::OFS_OPT_SUPPORT, 32'h0000_0010);
        rdc("ctrl", gfd_pkg::OFS_CTRL, 32'h0);
        rdc("unmapped", 8'h3C, 32'h0);
        $display("test reset done");

        wr(gfd_pkg::OFS_PRP2_LO, PRP2[31:0]);
        wr(gfd_pkg::OFS_PRP2_HI, PRP2[63:32]);
        wr(gfd_pkg::OFS_CFG_CAP, 32'h0000_000D);
        cfg(8'h03, 32'hA5A5_0003, 32'h8);
        cfg(8'h03, 32'h1111_0003, 32'h2);
        run(32'hFFFF_F803, 12'h000, 1'b0, 32'h1111_0003, 1'b1, 1'b0);
        run(32'h0000_0103, 12'h000, 1'b0, 32'hA5A5_0003, 1'b1, 1'b0);
        run(32'h0000_0203, 12'h000, 1'b0, 32'hA5A5_0003, 1'b1, 1'b0);
        rdc("status", gfd_pkg::OFS_STATUS, 32'h0000_0122);
        cfg(8'h03, 32'h2222_0003, 32'h6);
        run(32'h0000_0203, 12'h000, 1'b0, 32'h2222_0003, 1'b1, 1'b0);
        run(32'h0000_0303, 12'h000, 1'b0, 32'h0000_0005, 1'b0, 1'b0);
        run(32'h0000_0003, 12'hFE0, 1'b0, 32'h2222_0003, 1'b1, 1'b1);
        rdc("xfer2_lo", gfd_pkg::OFS_XFER2_LO, PRP2[31:0]);
        run(32'h0000_0003, 12'hFC0, 1'b0, 32'h2222_0003, 1'b1, 1'b0);
        $display("test saveable feature done");

        for (int s = 4; s < 8; s++)
            run({21'h0, 3'(s), 8'h03}, 12'h000, 1'b1, 32'h0, 1'b0, 1'b0);
        run(32'h0000_0010, 12'h000, 1'b1, 32'h0, 1'b0, 1'b0);
        rdc("status", gfd_pkg::OFS_STATUS, 32'h0000_000A);
        $display("test invalid fields done");

        wr(gfd_pkg::OFS_CFG_CAP, 32'h0);
        cfg(8'h05, 32'h0000_0077, 32'h8);
        cfg(8'h05, 32'h0000_0088, 32'h6);
        run(32'h0000_0205, 12'hFE0, 1'b0, 32'h0000_0077, 1'b0, 1'b0);
        rdc("status", gfd_pkg::OFS_STATUS, 32'h0000_0102);
        run(32'h0000_0005, 12'hFE0, 1'b0, 32'h0000_0088, 1'b0, 1'b0);
        $display("test plain feature done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
